// >>> src/key_if.sv
/*
  Carries synchronised key press pulses and the trip level from the
  input conditioner to the lock logic. Both ends share one clock.
*/
`timescale 1ns/100ps
interface key_if;
  logic fn;
  logic left;
  logic right;
  logic up;
  logic down;
  logic enter;
  logic any;
  logic trip_ok;
  modport src (output fn, left, right, up, down, enter, any, trip_ok);
  modport dst (input  fn, left, right, up, down, enter, any, trip_ok);
endinterface

// >>> src/key_sync.sv
/*
  Brings the front-panel keys and the external trip contact into the
  clock domain and turns key levels into one-cycle press pulses.
  Assumes keys are active high and already debounced outside.
*/
`timescale 1ns/100ps
module key_sync (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic [klock_pkg::KEY_N-1:0] key_pins,
  input  wire logic                       trip_pin,
  key_if.src                              k
);
  typedef struct packed {
    logic [klock_pkg::KEY_N:0] m1;
    logic [klock_pkg::KEY_N:0] m2;
    logic [klock_pkg::KEY_N:0] m3;
  } sync_t;

  sync_t s_q;
  sync_t s_d;
  logic [klock_pkg::KEY_N-1:0] press;

  always_comb begin
    s_d    = s_q;
    s_d.m1 = {trip_pin, key_pins};
    s_d.m2 = s_q.m1;
    s_d.m3 = s_q.m2;
  end

  // The trip contact resets closed so a dead input reads as a trip only later.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{m1: 7'h40, m2: 7'h40, m3: 7'h40};
    end else begin
      s_q <= s_d;
    end
  end

  assign press     = s_q.m2[klock_pkg::KEY_N-1:0] & ~s_q.m3[klock_pkg::KEY_N-1:0];
  assign k.fn      = press[klock_pkg::KEY_FN];
  assign k.left    = press[klock_pkg::KEY_LEFT];
  assign k.right   = press[klock_pkg::KEY_RIGHT];
  assign k.up      = press[klock_pkg::KEY_UP];
  assign k.down    = press[klock_pkg::KEY_DOWN];
  assign k.enter   = press[klock_pkg::KEY_ENTER];
  assign k.any     = |press;
  assign k.trip_ok = s_q.m2[klock_pkg::KEY_N];
endmodule

// >>> src/keypad_parameter_lock.sv
/*
  Front-panel programming logic: function selection, digit editing,
  password set, verify and clear, edit lock with idle timeout, trip
  handling and bypass pilot control.
  Assumes key and trip pins are raw levels; run, at-speed and overload
  signals come from logic on the same clock.
*/
// Notes on behaviour
// - Function key from status shows the first function number.
// - Left and right move the selected digit; up and down change it.
// - Password function with no password shows the code for all zeros.
// - First arrow after the code clears the display to zeros.
// - A stored password must be matched before a new one is taken.
// - Password entries above the maximum are refused.
// - A stored new password flashes a stored mark, then the function number.
// - Matching entry flashes accept; mismatch flashes reject.
// - Factory restore leaves the password untouched.
// - Storing all zeros removes the password and the lock.
// - An open trip input stops the motor and shows a fault.
// - At speed after a start, the bypass pilot is energised.
// - Internal overload protection can be switched off by configuration.
// - Unlock lasts five minutes after the last key press.
// - While locked, committing a change is refused with reject.
`timescale 1ns/100ps
module keypad_parameter_lock #(
  parameter longint LOCK_CYCLES  = klock_pkg::LOCK_CYCLES,
  parameter longint FLASH_CYCLES = klock_pkg::FLASH_CYCLES
) (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [klock_pkg::KEY_N-1:0] key_pins,
  input  wire logic                        trip_pin,
  input  wire logic                        run_cmd,
  input  wire logic                        at_speed,
  input  wire logic                        ol_trip,
  input  wire logic                        ol_enable,
  output logic      [15:0]                 disp_digits,
  output klock_pkg::disp_t                 disp_kind,
  output logic                             lock_active,
  output logic                             motor_on,
  output logic                             bypass_pilot,
  output logic                             param_commit,
  output logic      [15:0]                 commit_fn,
  output logic      [15:0]                 commit_val,
  output logic                             factory_restore
);
  localparam logic [klock_pkg::IDLE_W-1:0]  IDLE_LIM  =
    klock_pkg::IDLE_W'(LOCK_CYCLES - 1);
  localparam logic [klock_pkg::FLASH_W-1:0] FLASH_LIM =
    klock_pkg::FLASH_W'(FLASH_CYCLES - 1);

  typedef struct packed {
    klock_pkg::state_t          st;
    logic [15:0]                dig;
    logic [15:0]                fnum;
    logic [1:0]                 sel;
    logic [15:0]                pw;
    logic                       unlocked;
    logic [klock_pkg::IDLE_W-1:0]  idle;
    logic [klock_pkg::FLASH_W-1:0] flash;
    klock_pkg::disp_t           ind;
    logic                       fault;
    logic                       motor;
    logic                       bypass;
    logic                       lock;
    logic                       commit;
    logic                       restore;
    klock_pkg::disp_t           kind;
    logic [15:0]                show;
  } lock_t;

  logic [1:0] rs_q;
  logic       rst_s_n;
  lock_t      s;
  lock_t      n;
  logic       locked;
  logic       ol_hit;
  logic       edit_en;
  logic [1:0] sel_max;
  logic       go;
  klock_pkg::disp_t go_ind;

  key_if k ();

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rs_q <= 2'h0;
    end else begin
      rs_q <= {rs_q[0], 1'b1};
    end
  end
  assign rst_s_n = rs_q[1];

  key_sync u_keys (
    .clk      (clk),
    .rst_n    (rst_s_n),
    .key_pins (key_pins),
    .trip_pin (trip_pin),
    .k        (k.src)
  );

  // Digit-wise addition of the hiding code, so 0000 shows as the code itself.
  function automatic logic [15:0] encode(input logic [15:0] v);
    logic [4:0]  t;
    logic [15:0] r;
    r = 16'h0;
    for (int i = 0; i < 4; i++) begin
      t = {1'b0, v[4*i+:4]} + {1'b0, klock_pkg::PW_CODE[4*i+:4]};
      if (t > 5'h09) begin
        t = t - 5'h0a;
      end
      r[4*i+:4] = t[3:0];
    end
    return r;
  endfunction

  function automatic logic [3:0] step(input logic [3:0] d, input logic up);
    if (up) begin
      return (d >= klock_pkg::DIGIT_MAX) ? 4'h0 : d + 4'h1;
    end
    return (d == 4'h0) ? klock_pkg::DIGIT_MAX : d - 4'h1;
  endfunction

  always_comb begin
    n         = s;
    n.commit  = 1'b0;
    n.restore = 1'b0;
    edit_en   = 1'b0;
    sel_max   = klock_pkg::VALUE_SEL_MAX;
    go        = 1'b0;
    go_ind    = klock_pkg::DK_ERR;
    locked    = (s.pw != klock_pkg::PW_NONE) && !s.unlocked;
    ol_hit    = ol_trip && ol_enable;

    // Any key restarts the window; silence past the limit locks again.
    if (k.any) begin
      n.idle = '0;
    end else if (s.unlocked) begin
      if (s.idle >= IDLE_LIM) begin
        n.unlocked = 1'b0;
        n.idle     = '0;
      end else begin
        n.idle = s.idle + 1'b1;
      end
    end

    case (s.st)
      klock_pkg::ST_STATUS: begin
        if (k.fn) begin
          n.st  = klock_pkg::ST_FUNC;
          n.dig = klock_pkg::FIRST_FUNCTION_ENTRY;
          n.sel = 2'h0;
        end
      end
      klock_pkg::ST_FUNC: begin
        if (k.fn) begin
          n.st = klock_pkg::ST_STATUS;
        end else if (k.enter) begin
          n.fnum = s.dig;
          n.sel  = 2'h0;
          if (s.dig == klock_pkg::PASSWORD_FUNCTION) begin
            n.st = klock_pkg::ST_PW_CODE;
          end else if (s.dig == klock_pkg::FACTORY_RESTORE_FUNCTION) begin
            go = 1'b1;
            if (locked) begin
              go_ind = klock_pkg::DK_ERR;
            end else begin
              n.restore = 1'b1;
              go_ind    = klock_pkg::DK_END;
            end
          end else begin
            n.st  = klock_pkg::ST_PARAM;
            n.dig = 16'h0;
          end
        end else begin
          edit_en = 1'b1;
          sel_max = klock_pkg::FUNC_SEL_MAX;
        end
      end
      klock_pkg::ST_PARAM: begin
        if (k.fn) begin
          n.st  = klock_pkg::ST_FUNC;
          n.dig = s.fnum;
          n.sel = 2'h0;
        end else if (k.enter) begin
          go = 1'b1;
          if (locked) begin
            go_ind = klock_pkg::DK_ERR;
          end else begin
            n.commit = 1'b1;
            go_ind   = klock_pkg::DK_END;
          end
        end else begin
          edit_en = 1'b1;
        end
      end
      klock_pkg::ST_PW_CODE: begin
        if (k.fn) begin
          n.st  = klock_pkg::ST_FUNC;
          n.dig = s.fnum;
        end else if (k.left || k.right || k.up || k.down) begin
          n.st  = klock_pkg::ST_PW_EDIT;
          n.dig = klock_pkg::PW_NONE;
          n.sel = 2'h0;
        end
      end
      klock_pkg::ST_PW_EDIT: begin
        if (k.fn) begin
          n.st  = klock_pkg::ST_FUNC;
          n.dig = s.fnum;
          n.sel = 2'h0;
        end else if (k.enter) begin
          go = 1'b1;
          if (s.dig > klock_pkg::PW_MAX) begin
            go_ind = klock_pkg::DK_ERR;
          end else if (locked) begin
            if (s.dig == s.pw) begin
              n.unlocked = 1'b1;
              go_ind     = klock_pkg::DK_PASS;
            end else begin
              go_ind = klock_pkg::DK_ERR;
            end
          end else begin
            n.pw   = s.dig;
            go_ind = klock_pkg::DK_END;
          end
        end else begin
          edit_en = 1'b1;
        end
      end
      klock_pkg::ST_FLASH: begin
        if (s.flash >= FLASH_LIM) begin
          n.st  = klock_pkg::ST_FUNC;
          n.dig = s.fnum;
          n.sel = 2'h0;
        end else begin
          n.flash = s.flash + 1'b1;
        end
      end
      default: begin
        n.st = klock_pkg::ST_STATUS;
      end
    endcase

    if (edit_en) begin
      if (k.left && s.sel < sel_max) begin
        n.sel = s.sel + 2'h1;
      end else if (k.right && s.sel != 2'h0) begin
        n.sel = s.sel - 2'h1;
      end else if (k.up || k.down) begin
        n.dig[{s.sel, 2'h0}+:4] = step(s.dig[{s.sel, 2'h0}+:4], k.up);
      end
    end

    if (go) begin
      n.st    = klock_pkg::ST_FLASH;
      n.flash = '0;
      n.ind   = go_ind;
    end

    // A new trip wins over a clear requested in the same cycle.
    if (!k.trip_ok || ol_hit) begin
      n.fault = 1'b1;
    end else if (k.fn) begin
      n.fault = 1'b0;
    end
    n.motor  = run_cmd && !n.fault;
    n.bypass = n.motor && at_speed;
    n.lock   = (n.pw != klock_pkg::PW_NONE) && !n.unlocked;

    n.show = 16'h0;
    if (n.fault) begin
      n.kind = klock_pkg::DK_FAULT;
    end else begin
      case (n.st)
        klock_pkg::ST_STATUS: n.kind = klock_pkg::DK_STATUS;
        klock_pkg::ST_FUNC: begin
          n.kind = klock_pkg::DK_FUNC;
          n.show = n.dig;
        end
        klock_pkg::ST_PW_CODE: begin
          n.kind = klock_pkg::DK_CODE;
          n.show = encode(n.pw);
        end
        klock_pkg::ST_FLASH: n.kind = n.ind;
        default: begin
          n.kind = klock_pkg::DK_VALUE;
          n.show = n.dig;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_s_n) begin
    if (!rst_s_n) begin
      s <= '{st: klock_pkg::ST_STATUS, ind: klock_pkg::DK_ERR,
             kind: klock_pkg::DK_STATUS, default: '0};
    end else begin
      s <= n;
    end
  end

  assign disp_digits     = s.show;
  assign disp_kind       = s.kind;
  assign lock_active     = s.lock;
  assign motor_on        = s.motor;
  assign bypass_pilot    = s.bypass;
  assign param_commit    = s.commit;
  assign commit_fn       = s.fnum;
  assign commit_val      = s.dig;
  assign factory_restore = s.restore;

  logic quiet;
  assign quiet = k.trip_ok && !ol_hit && !s.fault;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_s_n);

  sequence s_pw_enter;
    s.st == klock_pkg::ST_PW_EDIT && k.enter && !k.fn && quiet;
  endsequence

  sequence s_store;
    s_pw_enter ##0 !locked && s.dig <= klock_pkg::PW_MAX;
  endsequence

  a_first_func: assert property (s.st == klock_pkg::ST_STATUS && k.fn && quiet
    |=> disp_kind == klock_pkg::DK_FUNC && disp_digits == 16'h0001)
    else $error("function key did not show the first function");
  a_digit_left: assert property (s.st == klock_pkg::ST_FUNC && k.left && !k.fn &&
    !k.enter && s.sel < 2'h2 |=> s.sel == $past(s.sel) + 2'h1)
    else $error("left arrow did not move the digit");
  a_code_zero: assert property (s.st == klock_pkg::ST_FUNC && k.enter && !k.fn &&
    s.dig == 16'h0070 && s.pw == 16'h0 && quiet |=> disp_digits == 16'h3552)
    else $error("empty password not shown as its code");
  a_arrow_clear: assert property (s.st == klock_pkg::ST_PW_CODE && k.up && !k.fn &&
    quiet |=> disp_digits == 16'h0 && disp_kind == klock_pkg::DK_VALUE)
    else $error("first arrow did not clear the display");
  a_range_err: assert property (s_pw_enter ##0 s.dig > 16'h0999
    |=> disp_kind == klock_pkg::DK_ERR && s.pw == $past(s.pw))
    else $error("out of range password accepted");
  a_store_end: assert property (s_store |=> disp_kind == klock_pkg::DK_END
    && s.pw == $past(s.dig))
    else $error("new password not stored with end mark");
  a_match_pass: assert property (s_pw_enter ##0 locked && s.dig == s.pw
    |=> disp_kind == klock_pkg::DK_PASS && !lock_active)
    else $error("matching password not accepted");
  a_miss_err: assert property (s_pw_enter ##0 locked && s.dig != s.pw
    |=> disp_kind == klock_pkg::DK_ERR && lock_active)
    else $error("wrong password not refused");
  a_restore_pw: assert property (factory_restore |-> $stable(s.pw))
    else $error("factory restore changed the password");
  a_zero_unlock: assert property (s_store ##0 s.dig == 16'h0 |=> !lock_active)
    else $error("zero password left the lock on");
  a_trip_stop: assert property (!k.trip_ok |=> !motor_on &&
    disp_kind == klock_pkg::DK_FAULT ##1 !bypass_pilot)
    else $error("trip did not stop the motor");
  a_bypass_speed: assert property (bypass_pilot |-> motor_on && $past(at_speed))
    else $error("bypass pilot without speed or motor");
  a_ol_off: assert property (!ol_enable && ol_trip && quiet |=> !s.fault)
    else $error("disabled overload still tripped");
  a_idle_relock: assert property (s.unlocked && !k.any && s.idle >= IDLE_LIM
    |=> !s.unlocked)
    else $error("lock not restored after idle window");
  a_key_window: assert property (k.any |=> s.idle == '0)
    else $error("key press did not restart the window");
  a_locked_commit: assert property (s.st == klock_pkg::ST_PARAM && k.enter &&
    !k.fn && locked |=> !param_commit && s.ind == klock_pkg::DK_ERR)
    else $error("commit accepted while locked");
  a_code_hidden: assert property (disp_kind == klock_pkg::DK_CODE
    |-> disp_digits == encode(s.pw))
    else $error("password shown without encoding");
endmodule

// >>> src/klock_pkg.sv
/*
  Shared constants and types for the keypad parameter-lock block.
  Assumes a single 25 MHz system clock.
*/
package klock_pkg;
  localparam longint CLK_HZ        = 25_000_000;
  // Edit window after a good password, in seconds, and flash time in milliseconds.
  localparam longint LOCK_WINDOW_S = 300;
  localparam longint FLASH_MS      = 1000;
  localparam longint LOCK_CYCLES   = LOCK_WINDOW_S * CLK_HZ;
  localparam longint FLASH_CYCLES  = (FLASH_MS * CLK_HZ) / 1000;
  localparam int     IDLE_W        = 33;
  localparam int     FLASH_W       = 25;

  // Key pin positions.
  localparam int KEY_FN    = 0;
  localparam int KEY_LEFT  = 1;
  localparam int KEY_RIGHT = 2;
  localparam int KEY_UP    = 3;
  localparam int KEY_DOWN  = 4;
  localparam int KEY_ENTER = 5;
  localparam int KEY_N     = 6;

  // Function numbers and password values, four BCD digits, then the digit select and digit value limits.
  localparam logic [15:0] FIRST_FUNCTION_ENTRY     = 16'h0001;
  localparam logic [15:0] PASSWORD_FUNCTION        = 16'h0070;
  localparam logic [15:0] FACTORY_RESTORE_FUNCTION = 16'h0071;
  localparam logic [15:0] PW_NONE                  = 16'h0000;
  localparam logic [15:0] PW_MAX                   = 16'h0999;
  localparam logic [15:0] PW_CODE                  = 16'h3552;
  localparam logic [1:0]  FUNC_SEL_MAX             = 2'h2;
  localparam logic [1:0]  VALUE_SEL_MAX            = 2'h3;
  localparam logic [3:0]  DIGIT_MAX                = 4'h9;

  typedef enum logic [2:0] {
    ST_STATUS, ST_FUNC, ST_PARAM, ST_PW_CODE, ST_PW_EDIT, ST_FLASH
  } state_t;

  typedef enum logic [2:0] {
    DK_STATUS, DK_FUNC, DK_VALUE, DK_CODE, DK_PASS, DK_ERR, DK_END, DK_FAULT
  } disp_t;
endpackage

// >>> testbench/keypad_operator.sv
/*
  Model of the front-panel operator: presses one key at a time.
  Assumes the same clock as the lock block and keys that need no debounce.
*/
`timescale 1ns/100ps
module keypad_operator (
  input  wire logic                        clk,
  output logic      [klock_pkg::KEY_N-1:0] key_pins
);
  initial key_pins = '0;

  // The key is held through the two-flop sync and the display update, so the
  // caller sees the answer on return; release lasts one cycle before a new press.
  task automatic press(input int k);
    @(posedge clk);
    key_pins[k] <= 1'b1;
    repeat (4) @(posedge clk);
    key_pins[k] <= 1'b0;
    #1;
  endtask

  task automatic tap(input int k, input int n);
    for (int i = 0; i < n; i++) begin
      press(k);
    end
  endtask
endmodule

// >>> testbench/testbench.sv
/*
  Self-checking bench for the keypad parameter lock.
  Assumes short lock and flash counts given as parameters to the block.
*/
`timescale 1ns/100ps
module testbench;
  localparam longint LOCK_CYC  = 200;
  localparam longint FLASH_CYC = 8;
  logic                        clk = 1'b0;
  logic                        rst_n = 1'b0;
  logic [klock_pkg::KEY_N-1:0] key_pins;
  logic                        trip_pin = 1'b1;
  logic                        run_cmd = 1'b0;
  logic                        at_speed = 1'b0;
  logic                        ol_trip = 1'b0;
  logic                        ol_enable = 1'b1;
  logic [15:0]                 disp_digits, commit_fn, commit_val, last_fn, last_val;
  klock_pkg::disp_t            disp_kind;
  logic                        lock_active, motor_on, bypass_pilot, param_commit;
  logic                        factory_restore;
  int                          n_fail = 0, total_checks = 0, cyc = 0;
  int                          n_commit = 0, n_restore = 0;

  always #20 clk = ~clk;

  keypad_parameter_lock #(.LOCK_CYCLES(LOCK_CYC), .FLASH_CYCLES(FLASH_CYC)) dut (
    .clk(clk), .rst_n(rst_n), .key_pins(key_pins), .trip_pin(trip_pin),
    .run_cmd(run_cmd), .at_speed(at_speed), .ol_trip(ol_trip), .ol_enable(ol_enable),
    .disp_digits(disp_digits), .disp_kind(disp_kind), .lock_active(lock_active),
    .motor_on(motor_on), .bypass_pilot(bypass_pilot), .param_commit(param_commit),
    .commit_fn(commit_fn), .commit_val(commit_val), .factory_restore(factory_restore));

  keypad_operator op (.clk(clk), .key_pins(key_pins));

  task automatic end_of_test;
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Pulses are counted here so that a missing or extra one is visible later.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (param_commit === 1'b1) begin
      n_commit <= n_commit + 1;
      last_fn  <= commit_fn;
      last_val <= commit_val;
    end
    if (factory_restore === 1'b1) begin
      n_restore <= n_restore + 1;
    end
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic ck(input klock_pkg::disp_t kind, input logic [15:0] digits);
    chk({13'h0000, disp_kind}, {13'h0000, kind});
    chk(disp_digits, digits);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic flash_done;
    wait_cyc(FLASH_CYC + 4);
  endtask

  task automatic to_status;
    for (int i = 0; i < 3; i++) begin
      if (disp_kind !== klock_pkg::DK_STATUS) begin
        op.press(klock_pkg::KEY_FN);
      end
    end
  endtask

  // Walks to 0070 with down set, otherwise stops at 0071.
  task automatic goto_fn(input logic down);
    to_status();
    op.press(klock_pkg::KEY_FN);
    op.press(klock_pkg::KEY_LEFT);
    op.tap(klock_pkg::KEY_UP, 7);
    op.press(klock_pkg::KEY_RIGHT);
    if (down) begin
      op.press(klock_pkg::KEY_DOWN);
    end
  endtask

  task automatic open_code;
    goto_fn(1'b1);
    op.press(klock_pkg::KEY_ENTER);
  endtask

  task automatic enter_pw(input int d3, input int d2, input int d1, input int d0);
    op.tap(klock_pkg::KEY_RIGHT, 3);
    op.tap(klock_pkg::KEY_UP, d0);
    op.press(klock_pkg::KEY_LEFT);
    op.tap(klock_pkg::KEY_UP, d1);
    op.press(klock_pkg::KEY_LEFT);
    op.tap(klock_pkg::KEY_UP, d2);
    op.press(klock_pkg::KEY_LEFT);
    op.tap(klock_pkg::KEY_UP, d3);
  endtask

  task automatic unlock;
    open_code();
    op.press(klock_pkg::KEY_UP);
    enter_pw(0, 1, 2, 3);
    op.press(klock_pkg::KEY_ENTER);
  endtask

  task automatic t_set_pw;
    to_status();
    op.press(klock_pkg::KEY_FN);
    ck(klock_pkg::DK_FUNC, 16'h0001);
    op.press(klock_pkg::KEY_LEFT);
    op.tap(klock_pkg::KEY_UP, 7);
    ck(klock_pkg::DK_FUNC, 16'h0071);
    op.press(klock_pkg::KEY_RIGHT);
    op.press(klock_pkg::KEY_DOWN);
    ck(klock_pkg::DK_FUNC, 16'h0070);
    op.press(klock_pkg::KEY_ENTER);
    ck(klock_pkg::DK_CODE, 16'h3552);
    op.press(klock_pkg::KEY_UP);
    ck(klock_pkg::DK_VALUE, 16'h0000);
    enter_pw(0, 1, 2, 3);
    chk(disp_digits, 16'h0123);
    op.press(klock_pkg::KEY_ENTER);
    ck(klock_pkg::DK_END, 16'h0000);
    chk({15'h0, lock_active}, 16'h0001);
    flash_done();
    ck(klock_pkg::DK_FUNC, 16'h0070);
    $display("t_set_pw done");
  endtask

  task automatic t_locked;
    goto_fn(1'b0);
    op.press(klock_pkg::KEY_ENTER);
    ck(klock_pkg::DK_ERR, 16'h0000);
    flash_done();
    to_status();
    op.press(klock_pkg::KEY_FN);
    op.press(klock_pkg::KEY_ENTER);
    op.press(klock_pkg::KEY_ENTER);
    ck(klock_pkg::DK_ERR, 16'h0000);
    flash_done();
    chk(16'(n_commit + n_restore), 16'h0000);
    $display("t_locked done");
  endtask

  task automatic t_verify;
    open_code();
    ck(klock_pkg::DK_CODE, 16'h3675);
    op.press(klock_pkg::KEY_UP);
    op.press(klock_pkg::KEY_ENTER);
    ck(klock_pkg::DK_ERR, 16'h0000);
    chk({15'h0, lock_active}, 16'h0001);
    flash_done();
    unlock();
    ck(klock_pkg::DK_PASS, 16'h0000);
    chk({15'h0, lock_active}, 16'h0000);
    flash_done();
    to_status();
    op.press(klock_pkg::KEY_FN);
    op.press(klock_pkg::KEY_ENTER);
    op.press(klock_pkg::KEY_UP);
    op.press(klock_pkg::KEY_ENTER);
    wait_cyc(2);
    chk(16'(n_commit), 16'h0001);
    chk(last_fn, 16'h0001);
    chk(last_val, 16'h0001);
    goto_fn(1'b0);
    op.press(klock_pkg::KEY_ENTER);
    wait_cyc(2);
    chk(16'(n_restore), 16'h0001);
    flash_done();
    $display("t_verify done");
  endtask

  task automatic t_idle;
    wait_cyc(150);
    chk({15'h0, lock_active}, 16'h0000);
    op.press(klock_pkg::KEY_FN);
    wait_cyc(150);
    chk({15'h0, lock_active}, 16'h0000);
    wait_cyc(80);
    chk({15'h0, lock_active}, 16'h0001);
    open_code();
    ck(klock_pkg::DK_CODE, 16'h3675);
    $display("t_idle done");
  endtask

  task automatic t_clear;
    op.press(klock_pkg::KEY_FN);
    unlock();
    flash_done();
    open_code();
    op.press(klock_pkg::KEY_UP);
    enter_pw(1, 0, 0, 0);
    op.press(klock_pkg::KEY_ENTER);
    ck(klock_pkg::DK_ERR, 16'h0000);
    flash_done();
    open_code();
    op.press(klock_pkg::KEY_UP);
    op.press(klock_pkg::KEY_ENTER);
    ck(klock_pkg::DK_END, 16'h0000);
    flash_done();
    chk({15'h0, lock_active}, 16'h0000);
    open_code();
    ck(klock_pkg::DK_CODE, 16'h3552);
    $display("t_clear done");
  endtask

  // Every input change waits for a rising edge, since checks leave the bench off the edge.
  task automatic t_trip;
    @(posedge clk);
    run_cmd <= 1'b1;
    wait_cyc(3);
    chk({14'h0, motor_on, bypass_pilot}, 16'h0002);
    @(posedge clk);
    at_speed <= 1'b1;
    wait_cyc(3);
    chk({14'h0, motor_on, bypass_pilot}, 16'h0003);
    @(posedge clk);
    trip_pin <= 1'b0;
    wait_cyc(5);
    chk({14'h0, motor_on, bypass_pilot}, 16'h0000);
    chk({13'h0000, disp_kind}, {13'h0000, klock_pkg::DK_FAULT});
    @(posedge clk);
    trip_pin <= 1'b1;
    wait_cyc(4);
    chk({15'h0, motor_on}, 16'h0000);
    op.press(klock_pkg::KEY_FN);
    wait_cyc(2);
    chk({15'h0, motor_on}, 16'h0001);
    @(posedge clk);
    ol_enable <= 1'b0;
    ol_trip   <= 1'b1;
    wait_cyc(3);
    chk({15'h0, motor_on}, 16'h0001);
    @(posedge clk);
    ol_enable <= 1'b1;
    wait_cyc(3);
    chk({15'h0, motor_on}, 16'h0000);
    @(posedge clk);
    run_cmd <= 1'b0;
    $display("t_trip done");
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wait_cyc(5);
    ck(klock_pkg::DK_STATUS, 16'h0000);
    chk({15'h0, lock_active}, 16'h0000);
    t_set_pw();
    t_locked();
    t_verify();
    t_idle();
    t_clear();
    t_trip();
    end_of_test();
  end
endmodule
